// ==== design/mfp_pkg.sv ====
// constants, register map and screen codes for the front-panel setup controller
package mfp_pkg;
   // register byte offsets
   localparam logic [7:0] MFP_OFF_NODE   = 8'h00;
   localparam logic [7:0] MFP_OFF_LINK   = 8'h04;
   localparam logic [7:0] MFP_OFF_SHUNT  = 8'h08;
   localparam logic [7:0] MFP_OFF_SENSOR = 8'h0C;
   localparam logic [7:0] MFP_OFF_PASS   = 8'h10;
   localparam logic [7:0] MFP_OFF_STATUS = 8'h14;
   // field positions
   localparam int MFP_LINK_PAR_POS  = 8;
   localparam int MFP_SENS_RNG_POS  = 16;
   localparam int MFP_STAT_SCR_POS  = 4;
   localparam int MFP_STAT_ICON_POS = 8;
   // reset values and permitted ranges
   localparam logic [7:0]  MFP_NODE_RST   = 8'h01;
   localparam logic [7:0]  MFP_NODE_MIN   = 8'h01;
   localparam logic [7:0]  MFP_NODE_MAX   = 8'hF7;
   localparam logic [2:0]  MFP_BAUD_RST   = 3'h4;
   localparam logic [2:0]  MFP_BAUD_LAST  = 3'h5;
   localparam logic [1:0]  MFP_PAR_RST    = 2'h2;
   localparam logic [6:0]  MFP_SHUNT_RST  = 7'h64;
   localparam logic [6:0]  MFP_SHUNT_MIN  = 7'h32;
   localparam logic [6:0]  MFP_SHUNT_MAX  = 7'h64;
   localparam logic [11:0] MFP_VRATE_RST  = 12'h000;
   localparam logic [11:0] MFP_VRATE_MAX  = 12'hBB8;
   localparam logic [15:0] MFP_PASS_RST   = 16'h0000;
   localparam logic [1:0]  MFP_CLR_YES    = 2'h2;
   // comm icon hold time
   localparam int MFP_CLOCK_KHZ    = 125000;
   localparam int MFP_COMM_HOLD_MS = 1000;
   localparam int MFP_COMM_HOLD_CY = MFP_COMM_HOLD_MS * MFP_CLOCK_KHZ;
   // axi responses
   localparam logic [1:0] MFP_RESP_OKAY   = 2'h0;
   localparam logic [1:0] MFP_RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      SCR_PASS   = 4'h0,
      SCR_NODE   = 4'h1,
      SCR_BAUD   = 4'h2,
      SCR_PARITY = 4'h3,
      SCR_SHUNT  = 4'h4,
      SCR_CRANGE = 4'h5,
      SCR_VRATE  = 4'h6,
      SCR_ECLR   = 4'h7,
      SCR_DCLR   = 4'h8
   } mfp_screen_t;

   // four packed decimal digits to binary
   function automatic logic [13:0] mfp_bcd_to_bin(input logic [15:0] d);
      // every term at full width, so a thousands digit above one cannot wrap
      mfp_bcd_to_bin = 14'(d[15:12]) * 14'h3E8 + 14'(d[11:8]) * 14'h064 + 14'(d[7:4]) * 14'h00A + 14'(d[3:0]);
   endfunction
endpackage

// ==== design/mfp_digit_edit.sv ====
// four-digit flashing-cursor editor driven by two keys
module mfp_digit_edit
   import mfp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic        inc,
   input  wire logic        adv,
   output logic [15:0]      digits,
   output logic [1:0]       pos,
   output logic             active,
   output logic             done
);
   logic [15:0] dig_q, dig_d;
   logic [1:0]  pos_q, pos_d;
   logic        act_q, act_d;

   // last digit confirm commits the value and stops the flashing
   assign done = act_q && adv && (pos_q == 2'h3);

   // cursor and digit updates; each edit starts from zero
   always_comb
   begin
      dig_d = dig_q;
      pos_d = pos_q;
      act_d = act_q;
      if (abort)
      begin
         act_d = 1'b0;
      end
      else if (start && !act_q)
      begin
         dig_d = 16'h0000;
         pos_d = 2'h0;
         act_d = 1'b1;
      end
      else if (act_q && inc)
      begin
         // the flashing digit counts 0..9 and wraps
         for (int i = 0; i < 4; i++)
         begin
            if (pos_q == 2'(i))
            begin
               dig_d[15 - 4*i -: 4] = (dig_q[15 - 4*i -: 4] == 4'h9) ? 4'h0 : 4'(dig_q[15 - 4*i -: 4] + 4'h1);
            end
         end
      end
      else if (act_q && adv)
      begin
         pos_d = 2'(pos_q + 2'h1);
         act_d = (pos_q != 2'h3);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dig_q <= 16'h0000;
         pos_q <= 2'h0;
         act_q <= 1'b0;
      end
      else
      begin
         dig_q <= dig_d;
         pos_q <= pos_d;
         act_q <= act_d;
      end
   end

   assign digits = dig_q;
   assign pos    = pos_q;
   assign active = act_q;

   chk_last_digit_ends: assert property (@(posedge clk) disable iff (!rst_n)
      (act_q && adv && !inc && !abort && pos_q == 2'h3) |=> !act_q && pos_q == 2'h0)
      else $error("editor still active after last digit confirm");
endmodule

// ==== design/mfp_setup.sv ====
// front-panel setup controller: key handling, parameter store, indicators, axi4-lite registers
module mfp_setup
   import mfp_pkg::*;
#(
   parameter int COMM_HOLD_CYCLES = MFP_COMM_HOLD_CY
)
(
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   input  wire logic        KEY_SEL,
   input  wire logic        KEY_CFM,
   input  wire logic        VOLT_INDIRECT,
   input  wire logic        QUERY_SEEN,
   input  wire logic        RESP_SENT,
   output logic             SET_LED,
   output logic [1:0]       COMM_ICONS,
   output logic [1:0]       DISP_PAGE,
   output logic [3:0]       SCREEN,
   output logic [15:0]      EDIT_DIGITS,
   output logic [1:0]       EDIT_POS,
   output logic             EDIT_FLASH,
   output logic             CLEAR_YES,
   output logic             ENERGY_CLEAR,
   output logic             INPUT_COUNTER_CLEAR,
   output logic [7:0]       SLAVE_NODE,
   output logic [2:0]       BAUD_PARAM,
   output logic [1:0]       PARITY_PARAM,
   output logic [6:0]       SHUNT_MV,
   output logic             CUR_RANGE,
   output logic [11:0]      VOLT_RATING,
   input  wire logic [7:0]  AXI_AWADDR,
   input  wire logic        AXI_AWVALID,
   output logic             AXI_AWREADY,
   input  wire logic [31:0] AXI_WDATA,
   input  wire logic [3:0]  AXI_WSTRB,
   input  wire logic        AXI_WVALID,
   output logic             AXI_WREADY,
   output logic [1:0]       AXI_BRESP,
   output logic             AXI_BVALID,
   input  wire logic        AXI_BREADY,
   input  wire logic [7:0]  AXI_ARADDR,
   input  wire logic        AXI_ARVALID,
   output logic             AXI_ARREADY,
   output logic [31:0]      AXI_RDATA,
   output logic [1:0]       AXI_RRESP,
   output logic             AXI_RVALID,
   input  wire logic        AXI_RREADY
);
   // register index 0..5 for mapped word, 7 for unmapped
   function automatic logic [2:0] reg_index(input logic [7:0] a);
      reg_index = (a[1:0] == 2'h0 && a <= MFP_OFF_STATUS) ? a[4:2] : 3'h7;
   endfunction

   mfp_screen_t scr_q, scr_d;
   logic        set_q, set_d, yes_clr;
   logic [1:0]  page_q, page_d, clr_cnt_q, clr_cnt_d, icon_q, icon_d;
   logic [7:0]  node_q, node_d;
   logic [2:0]  baud_q, baud_d;
   logic [1:0]  par_q, par_d;
   logic [6:0]  shunt_q, shunt_d;
   logic        crng_q, crng_d, eclr_q, eclr_d, dclr_q, dclr_d;
   logic [11:0] vrate_q, vrate_d;
   logic [15:0] pass_q, pass_d, entered_q, entered_d;
   logic [26:0] hold_q, hold_d;
   logic        combo, sel, cfm, ed_act, ed_done, ed_start;
   logic [15:0] ed_dig;
   logic [1:0]  ed_pos;
   logic [13:0] ed_val;
   logic        numeric;
   // axi state
   logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, wr_go;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;

   // a press of both keys in one cycle is the mode combo, never a single key
   assign combo = KEY_SEL && KEY_CFM;
   assign sel   = KEY_SEL && !KEY_CFM;
   assign cfm   = KEY_CFM && !KEY_SEL;
   assign numeric  = scr_q inside {SCR_PASS, SCR_NODE, SCR_SHUNT, SCR_VRATE};
   assign ed_start = set_q && sel && numeric;
   assign ed_val   = mfp_bcd_to_bin(ed_dig);
   assign yes_clr  = (clr_cnt_q == MFP_CLR_YES);

   mfp_digit_edit u_edit (
      .clk    (CLOCK),
      .rst_n  (RESET_N),
      .start  (ed_start),
      .abort  (combo),
      .inc    (sel),
      .adv    (cfm),
      .digits (ed_dig),
      .pos    (ed_pos),
      .active (ed_act),
      .done   (ed_done)
   );

   // axi write path: address and data taken in either order, reply when both held
   assign AXI_AWREADY = !aw_q;
   assign AXI_WREADY  = !w_q;
   assign AXI_ARREADY = !rv_q;
   assign wr_go       = aw_q && w_q && !bv_q;
   always_comb
   begin
      aw_d  = aw_q;
      w_d   = w_q;
      bv_d  = bv_q;
      br_d  = br_q;
      awa_d = awa_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      rv_d  = rv_q;
      rr_d  = rr_q;
      rd_d  = rd_q;
      if (AXI_AWVALID && !aw_q)
      begin
         aw_d  = 1'b1;
         awa_d = AXI_AWADDR;
      end
      if (AXI_WVALID && !w_q)
      begin
         w_d  = 1'b1;
         wd_d = AXI_WDATA;
         ws_d = AXI_WSTRB; // strobe kept with its data: the master may move it once taken
      end
      if (wr_go)
      begin
         bv_d = 1'b1;
         br_d = (reg_index(awa_q) == 3'h7) ? MFP_RESP_SLVERR : MFP_RESP_OKAY;
      end
      if (bv_q && AXI_BREADY)
      begin
         bv_d = 1'b0;
         aw_d = 1'b0;
         w_d  = 1'b0;
      end
      if (AXI_ARVALID && !rv_q)
      begin
         rv_d = 1'b1;
         rr_d = MFP_RESP_OKAY;
         unique case (reg_index(AXI_ARADDR))
            3'h0:    rd_d = {24'h0, node_q};
            3'h1:    rd_d = {22'h0, par_q, 5'h0, baud_q};
            3'h2:    rd_d = {25'h0, shunt_q};
            3'h3:    rd_d = {15'h0, crng_q, 4'h0, vrate_q};
            3'h4:    rd_d = 32'h0; // passcode reads back as zero
            3'h5:    rd_d = {22'h0, icon_q, scr_q, 3'h0, set_q};
            default:
            begin
               rd_d = 32'h0;
               rr_d = MFP_RESP_SLVERR;
            end
         endcase
      end
      else if (rv_q && AXI_RREADY)
      begin
         rv_d = 1'b0;
      end
   end

   // comm indicator: query shows one icon, answer after it shows two, idle time clears
   always_comb
   begin
      icon_d = icon_q;
      hold_d = hold_q;
      if (QUERY_SEEN)
      begin
         icon_d = 2'h1;
         hold_d = 27'h0;
      end
      else if (RESP_SENT && icon_q != 2'h0)
      begin
         icon_d = 2'h2;
         hold_d = 27'h0;
      end
      else if (icon_q != 2'h0)
      begin
         hold_d = 27'(hold_q + 27'h1);
         if (hold_q == 27'(COMM_HOLD_CYCLES - 1))
         begin
            icon_d = 2'h0;
         end
      end
   end

   // mode, screen walk and parameter store; a key edit wins over a bus write that cycle
   always_comb
   begin
      set_d = set_q;  scr_d = scr_q;  page_d = page_q;  clr_cnt_d = clr_cnt_q;
      node_d = node_q;  baud_d = baud_q;  par_d = par_q;  shunt_d = shunt_q;
      crng_d = crng_q;  vrate_d = vrate_q;  pass_d = pass_q;  entered_d = entered_q;
      eclr_d = 1'b0;  dclr_d = 1'b0;
      // bus writes, range checked like key edits
      if (wr_go && ws_q[0])
      begin
         unique case (reg_index(awa_q))
            3'h0: if (wd_q[7:0] >= MFP_NODE_MIN && wd_q[7:0] <= MFP_NODE_MAX) node_d = wd_q[7:0];
            3'h1: if (wd_q[2:0] <= MFP_BAUD_LAST) baud_d = wd_q[2:0];
            3'h2: if (wd_q[6:0] >= MFP_SHUNT_MIN && wd_q[6:0] <= MFP_SHUNT_MAX && wd_q[7] == 1'b0) shunt_d = wd_q[6:0];
            3'h3: if (wd_q[11:0] <= MFP_VRATE_MAX) vrate_d = wd_q[11:0];
            3'h4: pass_d = wd_q[15:0];
            default: ;
         endcase
         if (reg_index(awa_q) == 3'h1 && ws_q[1])
         begin
            par_d = wd_q[MFP_LINK_PAR_POS +: 2];
         end
         if (reg_index(awa_q) == 3'h3 && ws_q[2])
         begin
            crng_d = wd_q[MFP_SENS_RNG_POS];
         end
      end
      if (combo)
      begin
         set_d     = !set_q;
         scr_d     = SCR_PASS;
         entered_d = 16'h0000;
         clr_cnt_d = 2'h0;
      end
      else if (!set_q)
      begin
         // metering display: the same two keys step through measured pages
         if (sel)
         begin
            page_d = 2'(page_q + 2'h1);
         end
         else if (cfm)
         begin
            page_d = 2'(page_q - 2'h1);
         end
      end
      else if (ed_done)
      begin
         unique case (scr_q)
            SCR_PASS:  entered_d = ed_dig;
            SCR_NODE:  if (ed_val >= 14'(MFP_NODE_MIN) && ed_val <= 14'(MFP_NODE_MAX)) node_d = ed_val[7:0];
            SCR_SHUNT: if (ed_val >= 14'(MFP_SHUNT_MIN) && ed_val <= 14'(MFP_SHUNT_MAX)) shunt_d = ed_val[6:0];
            SCR_VRATE: if (ed_val <= 14'(MFP_VRATE_MAX)) vrate_d = ed_val[11:0];
            default: ;
         endcase
      end
      else if (!ed_act && sel)
      begin
         unique case (scr_q)
            SCR_BAUD:   baud_d = (baud_q == MFP_BAUD_LAST) ? 3'h0 : 3'(baud_q + 3'h1);
            SCR_PARITY: par_d = 2'(par_q + 2'h1);
            SCR_CRANGE: crng_d = !crng_q;
            SCR_ECLR, SCR_DCLR: if (!yes_clr) clr_cnt_d = 2'(clr_cnt_q + 2'h1);
            default: ;
         endcase
      end
      else if (!ed_act && cfm)
      begin
         clr_cnt_d = 2'h0;
         unique case (scr_q)
            SCR_PASS:   if (entered_q == pass_q) scr_d = SCR_NODE;
            SCR_NODE:   scr_d = SCR_BAUD;
            SCR_BAUD:   scr_d = SCR_PARITY;
            SCR_PARITY: scr_d = SCR_SHUNT;
            SCR_SHUNT:  scr_d = SCR_CRANGE;
            SCR_CRANGE: scr_d = VOLT_INDIRECT ? SCR_VRATE : SCR_ECLR;
            SCR_VRATE:  scr_d = SCR_ECLR;
            SCR_ECLR:
            begin
               eclr_d = yes_clr;
               scr_d  = SCR_DCLR;
            end
            SCR_DCLR:
            begin
               dclr_d = yes_clr;
               scr_d  = SCR_NODE;
            end
            default: scr_d = SCR_PASS;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         set_q <= 1'b0;  scr_q <= SCR_PASS;  page_q <= 2'h0;  clr_cnt_q <= 2'h0;
         node_q <= MFP_NODE_RST;  baud_q <= MFP_BAUD_RST;  par_q <= MFP_PAR_RST;
         shunt_q <= MFP_SHUNT_RST;  crng_q <= 1'b0;  vrate_q <= MFP_VRATE_RST;
         pass_q <= MFP_PASS_RST;  entered_q <= 16'h0000;  eclr_q <= 1'b0;  dclr_q <= 1'b0;
         icon_q <= 2'h0;  hold_q <= 27'h0;
         aw_q <= 1'b0;  w_q <= 1'b0;  bv_q <= 1'b0;  rv_q <= 1'b0;
         awa_q <= 8'h00;  wd_q <= 32'h0;  rd_q <= 32'h0;  br_q <= 2'h0;  rr_q <= 2'h0;  ws_q <= 4'h0;
      end
      else
      begin
         set_q <= set_d;  scr_q <= scr_d;  page_q <= page_d;  clr_cnt_q <= clr_cnt_d;
         node_q <= node_d;  baud_q <= baud_d;  par_q <= par_d;
         shunt_q <= shunt_d;  crng_q <= crng_d;  vrate_q <= vrate_d;
         pass_q <= pass_d;  entered_q <= entered_d;  eclr_q <= eclr_d;  dclr_q <= dclr_d;
         icon_q <= icon_d;  hold_q <= hold_d;
         aw_q <= aw_d;  w_q <= w_d;  bv_q <= bv_d;  rv_q <= rv_d;
         awa_q <= awa_d;  wd_q <= wd_d;  rd_q <= rd_d;  br_q <= br_d;  rr_q <= rr_d;  ws_q <= ws_d;
      end
   end

   // outputs; the serial engine only ever answers with these settings, never masters
   assign SET_LED      = set_q;
   assign COMM_ICONS   = icon_q;
   assign DISP_PAGE    = page_q;
   assign SCREEN       = scr_q;
   assign EDIT_DIGITS  = ed_dig;
   assign EDIT_POS     = ed_pos;
   assign EDIT_FLASH   = ed_act;
   assign CLEAR_YES    = yes_clr;
   assign ENERGY_CLEAR = eclr_q;
   assign INPUT_COUNTER_CLEAR = dclr_q;
   assign SLAVE_NODE   = node_q;
   assign BAUD_PARAM   = baud_q;
   assign PARITY_PARAM = par_q;
   assign SHUNT_MV     = shunt_q;
   assign CUR_RANGE    = crng_q;
   assign VOLT_RATING  = vrate_q;
   assign AXI_BVALID   = bv_q;
   assign AXI_BRESP    = br_q;
   assign AXI_RVALID   = rv_q;
   assign AXI_RDATA    = rd_q;
   assign AXI_RRESP    = rr_q;

   chk_combo_enter: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (!set_q && combo) |=> set_q && scr_q == SCR_PASS) else $error("combo did not enter setting mode");
   chk_combo_exit: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (set_q && combo) |=> !set_q) else $error("combo did not leave setting mode");
   chk_led_follows: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      combo |=> SET_LED != $past(SET_LED)) else $error("setting indicator did not follow mode");
   chk_icon_query: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      QUERY_SEEN |=> COMM_ICONS == 2'h1 ##1 (COMM_ICONS != 2'h0 || QUERY_SEEN)) else $error("query icon wrong");
   chk_icon_resp: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (RESP_SENT && !QUERY_SEEN && COMM_ICONS != 2'h0) |=> COMM_ICONS == 2'h2) else $error("response icon wrong");
   chk_node_range: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      SLAVE_NODE >= MFP_NODE_MIN && SLAVE_NODE <= MFP_NODE_MAX) else $error("node number out of range");
   chk_shunt_range: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      SHUNT_MV >= MFP_SHUNT_MIN && SHUNT_MV <= MFP_SHUNT_MAX) else $error("shunt span out of range");
   chk_vrate_skip: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (set_q && cfm && !ed_act && scr_q == SCR_CRANGE && !VOLT_INDIRECT) |=> scr_q == SCR_ECLR)
      else $error("voltage rating screen not skipped");
   chk_pass_gate: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (set_q && cfm && !ed_act && scr_q == SCR_PASS && entered_q != pass_q) |=> scr_q == SCR_PASS)
      else $error("wrong passcode let through");
   chk_energy_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      ENERGY_CLEAR |-> $past(scr_q) == SCR_ECLR && $past(clr_cnt_q) == MFP_CLR_YES && scr_q == SCR_DCLR)
      else $error("energy clear without yes");
endmodule

// ==== tb/mfp_op.sv ====
// behavioural operator at the two front-panel keys
module mfp_op
(
   input  wire logic clk,
   output logic      key_sel,
   output logic      key_cfm
);
   timeunit 1ns;
   timeprecision 1ps;

   // keys rest released
   initial
   begin
      key_sel = 1'h0;
      key_cfm = 1'h0;
   end

   // a press lasts one clock; gap is the hand's pause, so a slow operator is gap > 1
   task automatic press(input logic s, input logic c, input int gap = 1);
      key_sel <= s;
      key_cfm <= c;
      @(posedge clk);
      key_sel <= 1'h0;
      key_cfm <= 1'h0;
      repeat (gap) @(posedge clk);
   endtask

   task automatic sel(input int gap = 1);
      press(1'h1, 1'h0, gap);
   endtask

   task automatic cfm();
      press(1'h0, 1'h1);
   endtask

   task automatic both();
      press(1'h1, 1'h1);
   endtask

   // a number: open the editor, step each digit up from 0, confirm it
   task automatic enter(input logic [15:0] bcd);
      sel();
      for (int i = 3; i >= 0; i--)
      begin
         repeat (bcd[i*4 +: 4]) sel();
         cfm();
      end
   endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the front-panel setup controller
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mfp_pkg::*;

   // short icon hold keeps the idle expiry inside the run
   localparam int HOLD = 20;
   logic        CLOCK = 1'h0;
   logic        RESET_N, VOLT_INDIRECT, QUERY_SEEN, RESP_SENT;
   logic        KEY_SEL, KEY_CFM, SET_LED, EDIT_FLASH, CLEAR_YES, ENERGY_CLEAR, INPUT_COUNTER_CLEAR, CUR_RANGE;
   logic [1:0]  COMM_ICONS, DISP_PAGE, EDIT_POS, PARITY_PARAM, AXI_BRESP, AXI_RRESP, p;
   logic [3:0]  SCREEN, AXI_WSTRB;
   logic [15:0] EDIT_DIGITS;
   logic [7:0]  SLAVE_NODE, AXI_AWADDR, AXI_ARADDR;
   logic [2:0]  BAUD_PARAM;
   logic [6:0]  SHUNT_MV;
   logic [11:0] VOLT_RATING;
   logic [31:0] AXI_WDATA, AXI_RDATA;
   logic        AXI_AWVALID, AXI_WVALID, AXI_BREADY, AXI_ARVALID, AXI_RREADY;
   logic        AXI_AWREADY, AXI_WREADY, AXI_BVALID, AXI_ARREADY, AXI_RVALID;
   int          failures = 0, cmp_count = 0, clr_e = 0, clr_i = 0;

   mfp_setup #(.COMM_HOLD_CYCLES(HOLD)) i_mfp_setup (
      .CLOCK(CLOCK), .RESET_N(RESET_N), .KEY_SEL(KEY_SEL), .KEY_CFM(KEY_CFM), .VOLT_INDIRECT(VOLT_INDIRECT),
      .QUERY_SEEN(QUERY_SEEN), .RESP_SENT(RESP_SENT), .SET_LED(SET_LED), .COMM_ICONS(COMM_ICONS),
      .DISP_PAGE(DISP_PAGE), .SCREEN(SCREEN), .EDIT_DIGITS(EDIT_DIGITS), .EDIT_POS(EDIT_POS),
      .EDIT_FLASH(EDIT_FLASH), .CLEAR_YES(CLEAR_YES), .ENERGY_CLEAR(ENERGY_CLEAR),
      .INPUT_COUNTER_CLEAR(INPUT_COUNTER_CLEAR), .SLAVE_NODE(SLAVE_NODE), .BAUD_PARAM(BAUD_PARAM),
      .PARITY_PARAM(PARITY_PARAM), .SHUNT_MV(SHUNT_MV), .CUR_RANGE(CUR_RANGE), .VOLT_RATING(VOLT_RATING),
      .AXI_AWADDR(AXI_AWADDR), .AXI_AWVALID(AXI_AWVALID), .AXI_AWREADY(AXI_AWREADY), .AXI_WDATA(AXI_WDATA),
      .AXI_WSTRB(AXI_WSTRB), .AXI_WVALID(AXI_WVALID), .AXI_WREADY(AXI_WREADY), .AXI_BRESP(AXI_BRESP),
      .AXI_BVALID(AXI_BVALID), .AXI_BREADY(AXI_BREADY), .AXI_ARADDR(AXI_ARADDR), .AXI_ARVALID(AXI_ARVALID),
      .AXI_ARREADY(AXI_ARREADY), .AXI_RDATA(AXI_RDATA), .AXI_RRESP(AXI_RRESP), .AXI_RVALID(AXI_RVALID),
      .AXI_RREADY(AXI_RREADY)
   );
   mfp_op i_mfp_op (.clk(CLOCK), .key_sel(KEY_SEL), .key_cfm(KEY_CFM));

   always #4 CLOCK = ~CLOCK;

   // count clear pulses so a stuck or doubled pulse shows up
   always @(posedge CLOCK)
   begin
      clr_e <= clr_e + int'(ENERGY_CLEAR === 1'h1);
      clr_i <= clr_i + int'(INPUT_COUNTER_CLEAR === 1'h1);
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      AXI_AWADDR <= a;
      AXI_AWVALID <= 1'h1;
      AXI_WDATA <= d;
      AXI_WVALID <= 1'h1;
      AXI_BREADY <= 1'h1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge CLOCK);
         if (!aw_ok && AXI_AWREADY === 1'h1)
         begin
            aw_ok = 1'h1;
            AXI_AWVALID <= 1'h0;
         end
         if (!w_ok && AXI_WREADY === 1'h1)
         begin
            w_ok = 1'h1;
            AXI_WVALID <= 1'h0;
         end
      end
      do @(posedge CLOCK); while (AXI_BVALID !== 1'h1);
      chk("bresp", er, AXI_BRESP);
      AXI_BREADY <= 1'h0;
      @(posedge CLOCK);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      AXI_ARADDR <= a;
      AXI_ARVALID <= 1'h1;
      AXI_RREADY <= 1'h1;
      do @(posedge CLOCK); while (AXI_ARREADY !== 1'h1);
      AXI_ARVALID <= 1'h0;
      do @(posedge CLOCK); while (AXI_RVALID !== 1'h1);
      chk("rdata", ed, AXI_RDATA);
      chk("rresp", er, AXI_RRESP);
      AXI_RREADY <= 1'h0;
      @(posedge CLOCK);
   endtask

   // one link event, then one quiet edge so the icons settle
   task automatic link(input logic q, input logic r);
      QUERY_SEEN <= q;
      RESP_SENT <= r;
      @(posedge CLOCK);
      QUERY_SEEN <= 1'h0;
      RESP_SENT <= 1'h0;
      @(posedge CLOCK);
   endtask

   task automatic report_and_stop();
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // a hang is cut short well past the expected few hundred cycles
   initial
   begin
      repeat (20000) @(posedge CLOCK);
      failures++;
      report_and_stop();
   end

   initial
   begin
      // inputs idle and reset low from the start
      RESET_N = 1'h0;
      VOLT_INDIRECT = 1'h0;
      QUERY_SEEN = 1'h0;
      RESP_SENT = 1'h0;
      AXI_WSTRB = 4'hF;
      AXI_AWADDR = 8'h00;
      AXI_ARADDR = 8'h00;
      AXI_WDATA = 32'h0;
      AXI_AWVALID = 1'h0;
      AXI_WVALID = 1'h0;
      AXI_BREADY = 1'h0;
      AXI_ARVALID = 1'h0;
      AXI_RREADY = 1'h0;
      repeat (2) @(posedge CLOCK);
      RESET_N <= 1'h1;
      @(posedge CLOCK);
      chk("node", 8'h1, SLAVE_NODE);
      chk("parity", 2'h2, PARITY_PARAM);
      chk("shunt", 7'h64, SHUNT_MV);
      chk("range", 1'h0, CUR_RANGE);
      chk("set", 1'h0, SET_LED);
      axi_rd(MFP_OFF_LINK, 32'h204, MFP_RESP_OKAY);
      axi_rd(8'h18, 32'h0, MFP_RESP_SLVERR);
      axi_wr(8'h1C, 32'hFF, MFP_RESP_SLVERR);
      // every baud and parity code is kept; an unknown baud code is refused
      for (int b = 0; b < 6; b++)
      begin
         axi_wr(MFP_OFF_LINK, 32'(b) | 32'(3 - b % 4) << 8, MFP_RESP_OKAY);
         chk("baud", 32'(b), BAUD_PARAM);
         chk("parity", 32'(3 - b % 4), PARITY_PARAM);
      end
      axi_wr(MFP_OFF_LINK, 32'h206, MFP_RESP_OKAY);
      chk("baud", 3'h5, BAUD_PARAM);
      // low byte strobe only: baud moves, the parity byte stays masked
      AXI_WSTRB <= 4'h1;
      axi_wr(MFP_OFF_LINK, 32'h301, MFP_RESP_OKAY);
      AXI_WSTRB <= 4'hF;
      chk("baud", 3'h1, BAUD_PARAM);
      chk("parity", 2'h2, PARITY_PARAM);
      axi_wr(MFP_OFF_NODE, 32'h0, MFP_RESP_OKAY);
      axi_wr(MFP_OFF_NODE, 32'hF8, MFP_RESP_OKAY);
      chk("node", 8'h1, SLAVE_NODE);
      // stray answer ignored, query then answer, then expiry when idle
      link(1'h0, 1'h1);
      chk("icons", 2'h0, COMM_ICONS);
      link(1'h1, 1'h0);
      chk("icons", 2'h1, COMM_ICONS);
      link(1'h0, 1'h1);
      chk("icons", 2'h2, COMM_ICONS);
      repeat (HOLD / 2) @(posedge CLOCK);
      chk("icons", 2'h2, COMM_ICONS);
      repeat (HOLD) @(posedge CLOCK);
      chk("icons", 2'h0, COMM_ICONS);
      // metering pages with a slow hand
      p = DISP_PAGE;
      i_mfp_op.sel(5);
      chk("page", 2'(p + 2'h1), DISP_PAGE);
      i_mfp_op.cfm();
      chk("page", p, DISP_PAGE);
      // setting mode opens on the passcode screen; a wrong code is held there
      i_mfp_op.both();
      chk("set", 1'h1, SET_LED);
      axi_rd(MFP_OFF_STATUS, 32'h1, MFP_RESP_OKAY);
      i_mfp_op.enter(16'h0001);
      i_mfp_op.cfm();
      chk("screen", SCR_PASS, SCREEN);
      i_mfp_op.sel();
      chk("flash", 1'h1, EDIT_FLASH);
      repeat (4) i_mfp_op.cfm();
      chk("flash", 1'h0, EDIT_FLASH);
      i_mfp_op.cfm();
      chk("screen", SCR_NODE, SCREEN);
      i_mfp_op.enter(16'h0248);
      chk("node", 8'h1, SLAVE_NODE);
      i_mfp_op.enter(16'h0247);
      chk("node", 8'hF7, SLAVE_NODE);
      repeat (3) i_mfp_op.cfm();
      chk("screen", SCR_SHUNT, SCREEN);
      i_mfp_op.enter(16'h0049);
      chk("shunt", 7'h64, SHUNT_MV);
      i_mfp_op.enter(16'h0050);
      chk("shunt", 7'h32, SHUNT_MV);
      // direct-voltage meter skips the rating screen
      repeat (2) i_mfp_op.cfm();
      chk("screen", SCR_ECLR, SCREEN);
      i_mfp_op.sel();
      chk("yes", 1'h0, CLEAR_YES);
      i_mfp_op.sel();
      chk("yes", 1'h1, CLEAR_YES);
      i_mfp_op.cfm();
      chk("screen", SCR_DCLR, SCREEN);
      repeat (2) i_mfp_op.sel();
      i_mfp_op.cfm();
      @(posedge CLOCK);
      chk("e_clr", 32'h1, clr_e);
      chk("i_clr", 32'h1, clr_i);
      chk("screen", SCR_NODE, SCREEN);
      VOLT_INDIRECT <= 1'h1;
      repeat (5) i_mfp_op.cfm();
      chk("screen", SCR_VRATE, SCREEN);
      i_mfp_op.enter(16'h3001);
      chk("volt", 12'h0, VOLT_RATING);
      i_mfp_op.enter(16'h3000);
      chk("volt", 12'hBB8, VOLT_RATING);
      axi_wr(MFP_OFF_SENSOR, 32'h10BB8, MFP_RESP_OKAY);
      chk("range", 1'h1, CUR_RANGE);
      axi_rd(MFP_OFF_SENSOR, 32'h10BB8, MFP_RESP_OKAY);
      i_mfp_op.both();
      chk("set", 1'h0, SET_LED);
      axi_rd(MFP_OFF_NODE, 32'hF7, MFP_RESP_OKAY);
      axi_wr(MFP_OFF_PASS, 32'h1234, MFP_RESP_OKAY);
      axi_rd(MFP_OFF_PASS, 32'h0, MFP_RESP_OKAY);
      // the written code opens the setting screens; digits and cursor watched on the way
      i_mfp_op.both();
      chk("set", 1'h1, SET_LED);
      i_mfp_op.sel();
      i_mfp_op.sel();
      chk("digits", 16'h1000, EDIT_DIGITS);
      i_mfp_op.cfm();
      chk("pos", 2'h1, EDIT_POS);
      repeat (2) i_mfp_op.sel();
      i_mfp_op.cfm();
      repeat (3) i_mfp_op.sel();
      i_mfp_op.cfm();
      repeat (4) i_mfp_op.sel();
      i_mfp_op.cfm();
      chk("digits", 16'h1234, EDIT_DIGITS);
      i_mfp_op.cfm();
      chk("screen", SCR_NODE, SCREEN);
      // a reset in mid-run brings every setting back to its default
      RESET_N <= 1'h0;
      @(posedge CLOCK);
      RESET_N <= 1'h1;
      @(posedge CLOCK);
      chk("node", 8'h1, SLAVE_NODE);
      chk("set", 1'h0, SET_LED);
      chk("volt", 12'h0, VOLT_RATING);
      chk("range", 1'h0, CUR_RANGE);
      report_and_stop();
   end
endmodule
